// File: rtl/an_expansion_and_indicator_regs.sv
// expansion status and indicator configuration registers behind the management port
`timescale 1ns/1ps
module an_expansion_and_indicator_regs
  import an_indicator_pkg::*;
#(
  parameter int unsigned stretch_cycles = STRETCH_CYCLES,
  parameter logic [4:0]  phy_addr       = PHY_ADDR_DEFAULT
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // management port
  input  wire logic mdc,
  input  wire logic mdio_in,
  output logic      mdio_out,
  output logic      mdio_oe,
  // auto-negotiation status
  input  wire logic par_det_fault,
  input  wire logic page_received,
  input  wire logic lp_next_page_able,
  input  wire logic lp_an_able,
  // indicator sources
  input  wire logic tx_activity,
  input  wire logic rx_activity,
  input  wire logic link_up,
  input  wire logic half_duplex,
  input  wire logic speed_100,
  input  wire logic collision,
  // indicators and controls
  output logic      port_indicator_a,
  output logic      port_indicator_b,
  output logic      port_indicator_c,
  output logic      tx_pulse_tune,
  output logic      link_alg_sel
);
  typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} frame_state_e;

  frame_state_e state;
  logic [2:0]   mdc_sync;
  logic [2:0]   mdio_sync;
  logic         mdc_level;
  logic         mdc_rise;
  logic         bit_in;
  logic [5:0]   ones;
  logic [4:0]   cnt;
  logic [12:0]  hdr;
  logic [12:0]  next_hdr;
  logic         is_read;
  logic [4:0]   reg_addr;
  logic [15:0]  shift;
  logic [15:0]  read_word;
  logic         rd_clear;
  logic         wr_commit;
  logic         par_fault_flag;
  logic         page_rx_flag;
  logic [3:0]   scratch;
  logic [1:0]   sel_a;
  logic [1:0]   sel_b;
  logic [1:0]   sel_c;
  logic         stretch_disable;
  logic [2:0]   src;
  logic [2:0]   ind;

  // pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_sync  <= 3'h0;
      mdio_sync <= 3'h7;
      mdc_level <= 1'b0;
    end else begin
      mdc_sync  <= {mdc_sync[1:0], mdc};
      mdio_sync <= {mdio_sync[1:0], mdio_in};
      if (mdc_sync[1] == mdc_sync[2]) mdc_level <= mdc_sync[2];
    end
  end

  assign mdc_rise = (mdc_sync[1] == mdc_sync[2]) && mdc_sync[2] && !mdc_level;
  assign bit_in   = mdio_sync[2];
  assign next_hdr = {hdr[11:0], bit_in};

  // register read data
  always_comb begin
    read_word = 16'h0000;
    if (reg_addr == REG_AN_EXPANSION) begin
      read_word[EXP_PAR_FAULT]    = par_fault_flag;
      read_word[EXP_LP_NEXT_PAGE] = lp_next_page_able;
      read_word[EXP_PAGE_RX]      = page_rx_flag;
      read_word[EXP_LP_AN_ABLE]   = lp_an_able;
    end else if (reg_addr == REG_INDICATOR_CFG) begin
      read_word[CFG_SCRATCH_MSB:CFG_SCRATCH_LSB] = scratch;
      read_word[CFG_PULSE_TUNE]                  = tx_pulse_tune;
      read_word[CFG_C_SEL_LSB+:2]                = sel_c;
      read_word[CFG_B_SEL_LSB+:2]                = sel_b;
      read_word[CFG_A_SEL_LSB+:2]                = sel_a;
      read_word[CFG_LINK_ALG]                    = link_alg_sel;
      read_word[CFG_STRETCH_DIS]                 = stretch_disable;
    end
  end

  // management frame engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_PRE;
      ones      <= 6'h00;
      cnt       <= 5'h00;
      hdr       <= 13'h0000;
      is_read   <= 1'b0;
      reg_addr  <= 5'h00;
      shift     <= 16'h0000;
      mdio_out  <= 1'b0;
      mdio_oe   <= 1'b0;
      rd_clear  <= 1'b0;
      wr_commit <= 1'b0;
    end else begin
      rd_clear  <= 1'b0;
      wr_commit <= 1'b0;
      if (mdc_rise) begin
        case (state)
          ST_PRE: begin
            if (bit_in) begin
              if (ones != PREAMBLE_ONES) ones <= ones + 6'h01;
            end else if (ones == PREAMBLE_ONES) begin
              state <= ST_HDR;
              cnt   <= 5'h00;
              ones  <= 6'h00;
            end else begin
              ones <= 6'h00;
            end
          end
          ST_HDR: begin
            hdr <= next_hdr;
            cnt <= cnt + 5'h01;
            if (cnt == HDR_LAST) begin
              reg_addr <= next_hdr[4:0];
              is_read  <= (next_hdr[11:10] == OP_READ);
              cnt      <= 5'h00;
              if (next_hdr[12] && next_hdr[9:5] == phy_addr &&
                  (next_hdr[11:10] == OP_READ || next_hdr[11:10] == OP_WRITE)) begin
                state <= ST_TA;
              end else begin
                state <= ST_PRE;
              end
            end
          end
          ST_TA: begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h00) begin
              if (is_read) begin
                mdio_oe  <= 1'b1;
                mdio_out <= 1'b0;
                shift    <= read_word;
                rd_clear <= (reg_addr == REG_AN_EXPANSION);
              end
            end else begin
              state <= ST_DATA;
              cnt   <= 5'h00;
              if (is_read) begin
                mdio_out <= shift[15];
                shift    <= {shift[14:0], 1'b0};
              end
            end
          end
          ST_DATA: begin
            cnt <= cnt + 5'h01;
            if (is_read) begin
              mdio_out <= shift[15];
              shift    <= {shift[14:0], 1'b0};
            end else begin
              shift <= {shift[14:0], bit_in};
            end
            if (cnt == DATA_LAST) begin
              state     <= ST_PRE;
              mdio_oe   <= 1'b0;
              mdio_out  <= 1'b0;
              wr_commit <= !is_read && (reg_addr == REG_INDICATOR_CFG);
            end
          end
          default: state <= ST_PRE;
        endcase
      end
    end
  end

  // latching-high status flags, a set beats a read clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_fault_flag <= 1'b0;
      page_rx_flag   <= 1'b0;
    end else begin
      par_fault_flag <= par_det_fault | (par_fault_flag & ~rd_clear);
      page_rx_flag   <= page_received | (page_rx_flag & ~rd_clear);
    end
  end

  // indicator configuration register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scratch         <= RST_SCRATCH;
      tx_pulse_tune   <= RST_BIT;
      sel_c           <= RST_SEL;
      sel_b           <= RST_SEL;
      sel_a           <= RST_SEL;
      link_alg_sel    <= RST_BIT;
      stretch_disable <= RST_BIT;
    end else if (wr_commit) begin
      scratch         <= shift[CFG_SCRATCH_MSB:CFG_SCRATCH_LSB];
      tx_pulse_tune   <= shift[CFG_PULSE_TUNE];
      sel_c           <= shift[CFG_C_SEL_LSB+:2];
      sel_b           <= shift[CFG_B_SEL_LSB+:2];
      sel_a           <= shift[CFG_A_SEL_LSB+:2];
      link_alg_sel    <= shift[CFG_LINK_ALG];
      stretch_disable <= shift[CFG_STRETCH_DIS];
    end
  end

  // source selection
  always_comb begin
    case (sel_a)
      2'h0:    src[0] = tx_activity;
      2'h1:    src[0] = rx_activity;
      2'h2:    src[0] = link_up;
      default: src[0] = half_duplex;
    endcase
    case (sel_b)
      2'h0:    src[1] = rx_activity;
      2'h1:    src[1] = link_up;
      2'h2:    src[1] = half_duplex;
      default: src[1] = speed_100;
    endcase
    case (sel_c)
      2'h0:    src[2] = link_up;
      2'h1:    src[2] = half_duplex;
      2'h2:    src[2] = speed_100;
      default: src[2] = collision;
    endcase
  end

  for (genvar i = 0; i < 3; i++) begin : g_ind
    indicator_stretch #(
      .hold_cycles     (stretch_cycles)
    ) u_stretch (
      .clk             (clk),
      .rst_n           (rst_n),
      .stretch_disable (stretch_disable),
      .source          (src[i]),
      .indicator       (ind[i])
    );
  end

  assign port_indicator_a = ind[0];
  assign port_indicator_b = ind[1];
  assign port_indicator_c = ind[2];
endmodule // an_expansion_and_indicator_regs

// File: rtl/an_indicator_pkg.sv
// constants for the expansion status and indicator configuration registers
package an_indicator_pkg;
  // register addresses
  localparam logic [4:0] REG_AN_EXPANSION   = 5'h06;
  localparam logic [4:0] REG_INDICATOR_CFG  = 5'h10;
  // expansion status fields
  localparam int         EXP_PAR_FAULT      = 4;
  localparam int         EXP_LP_NEXT_PAGE   = 3;
  localparam int         EXP_PAGE_RX        = 1;
  localparam int         EXP_LP_AN_ABLE     = 0;
  // indicator configuration fields
  localparam int         CFG_SCRATCH_MSB    = 15;
  localparam int         CFG_SCRATCH_LSB    = 12;
  localparam int         CFG_PULSE_TUNE     = 8;
  localparam int         CFG_C_SEL_LSB      = 6;
  localparam int         CFG_B_SEL_LSB      = 4;
  localparam int         CFG_A_SEL_LSB      = 2;
  localparam int         CFG_LINK_ALG       = 1;
  localparam int         CFG_STRETCH_DIS    = 0;
  // reset values
  localparam logic [3:0] RST_SCRATCH        = 4'h0;
  localparam logic [1:0] RST_SEL            = 2'h0;
  localparam logic       RST_BIT            = 1'b0;
  // management frame layout
  localparam logic [5:0] PREAMBLE_ONES      = 6'h20;
  localparam logic [4:0] HDR_LAST           = 5'h0c;
  localparam logic [4:0] DATA_LAST          = 5'h0f;
  localparam logic [1:0] OP_READ            = 2'h2;
  localparam logic [1:0] OP_WRITE           = 2'h1;
  localparam logic [4:0] PHY_ADDR_DEFAULT   = 5'h00;
  // indicator stretch timing
  localparam int         CLK_FREQ_KHZ       = 200000;
  localparam int         STRETCH_TIME_MS    = 50;
  localparam int         STRETCH_CYCLES     = STRETCH_TIME_MS * CLK_FREQ_KHZ;
  localparam int         STRETCH_W          = 24;
endpackage

// File: rtl/indicator_stretch.sv
// one indicator output with optional stretch of its active time
`timescale 1ns/1ps
module indicator_stretch
  import an_indicator_pkg::*;
#(
  parameter int unsigned hold_cycles = STRETCH_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control and source
  input  wire logic stretch_disable,
  input  wire logic source,
  // indicator
  output logic      indicator
);
  logic [STRETCH_W-1:0] hold;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold      <= '0;
      indicator <= 1'b0;
    end else if (stretch_disable) begin
      hold      <= '0;
      indicator <= source;
    end else if (source) begin
      hold      <= STRETCH_W'(hold_cycles);
      indicator <= 1'b1;
    end else begin
      if (hold != '0) hold <= hold - 1'b1;
      indicator <= (hold > STRETCH_W'(1));
    end
  end
endmodule // indicator_stretch

// File: testbench/an_expansion_and_indicator_regs_bench.sv
// self-checking bench for the expansion and indicator register slice
`timescale 1ns/1ps
module an_expansion_and_indicator_regs_bench import an_indicator_pkg::*;;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       mdc, mdio_in, mdio_out, mdio_oe, ia, ib, ic, tune, alg;
  logic       fault = 1'b0;
  logic       page = 1'b0;
  logic       lpnp = 1'b0;
  logic       lpan = 1'b0;
  logic [5:0] src = 6'h00;
  logic [15:0] r;
  int         errors = 0;
  int         checks_done = 0;
  always #2.5 clk = ~clk;
  an_expansion_and_indicator_regs #(.stretch_cycles(8)) an_expansion_and_indicator_regs_inst (
    .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .par_det_fault(fault), .page_received(page),
    .lp_next_page_able(lpnp), .lp_an_able(lpan), .tx_activity(src[0]),
    .rx_activity(src[1]), .link_up(src[2]), .half_duplex(src[3]), .speed_100(src[4]),
    .collision(src[5]), .port_indicator_a(ia), .port_indicator_b(ib),
    .port_indicator_c(ic), .tx_pulse_tune(tune), .link_alg_sel(alg));
  mgmt_station mgmt_station_inst (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .mdc(mdc), .mdio_in(mdio_in));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk16(input logic [15:0] e, input logic [15:0] g, input string nm);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g, input string nm);
    chk16({15'h0000, e}, {15'h0000, g}, nm);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mgmt_station_inst.xfer(PHY_ADDR_DEFAULT, OP_WRITE, ra, d, x);
    tick(4);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] e, input string nm);
    mgmt_station_inst.xfer(PHY_ADDR_DEFAULT, OP_READ, ra, 16'h0000, r);
    chk16(e, r, nm);
  endtask
  task automatic sc_rw();
    rd(REG_INDICATOR_CFG, 16'h0000, "cfg reset");
    rd(REG_AN_EXPANSION, 16'h0000, "exp reset");
    wr(REG_INDICATOR_CFG, 16'hffff);
    rd(REG_INDICATOR_CFG, 16'hf1ff, "cfg all ones");
    chk1(1'b1, tune, "tune");
    chk1(1'b1, alg, "alg");
    wr(5'h11, 16'hffff);
    rd(5'h11, 16'h0000, "unmapped");
    wr(REG_AN_EXPANSION, 16'hffff);
    rd(REG_AN_EXPANSION, 16'h0000, "exp write");
    mgmt_station_inst.xfer(PHY_ADDR_DEFAULT, 2'b11, REG_INDICATOR_CFG, 16'h0000, r);
    rd(REG_INDICATOR_CFG, 16'hf1ff, "bad opcode ignored");
    mgmt_station_inst.xfer(5'h01, OP_READ, REG_INDICATOR_CFG, 16'h0000, r);
    chk16(16'hffff, r, "other address");
  endtask
  task automatic sc_mux();
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      wr(REG_INDICATOR_CFG, {8'h00, s, s, s, 2'b01});
      chk1(1'b0, tune, "tune clear");
      for (int k = 0; k < 6; k++) begin
        src = 6'h01 << k;
        tick(4);
        chk1(k == i, ia, "indicator a");
        chk1(k == i + 1, ib, "indicator b");
        chk1(k == i + 2, ic, "indicator c");
      end
      src = 6'h00;
    end
  endtask
  task automatic sc_stretch();
    wr(REG_INDICATOR_CFG, 16'h0000);
    src = 6'h01;
    tick(3);
    src = 6'h00;
    tick(4);
    chk1(1'b1, ia, "stretched");
    tick(12);
    chk1(1'b0, ia, "stretch end");
  endtask
  task automatic sc_flags();
    lpnp = 1'b1;
    lpan = 1'b1;
    fault = 1'b1;
    page = 1'b1;
    tick(1);
    fault = 1'b0;
    page = 1'b0;
    rd(REG_AN_EXPANSION, 16'h001b, "exp latched");
    rd(REG_AN_EXPANSION, 16'h0009, "exp cleared");
    fault = 1'b1;
    rd(REG_AN_EXPANSION, 16'h0019, "fault held");
    fault = 1'b0;
    rd(REG_AN_EXPANSION, 16'h0019, "fault kept");
    rd(REG_AN_EXPANSION, 16'h0009, "fault cleared");
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  initial begin
    tick(6);
    rst_n = 1'b1;
    tick(4);
    chk1(1'b0, tune, "tune reset");
    chk1(1'b0, alg, "alg reset");
    sc_rw();
    sc_mux();
    sc_stretch();
    sc_flags();
    report_and_stop();
  end
endmodule // an_expansion_and_indicator_regs_bench

// File: testbench/an_indicator_properties.sv
// checker for the expansion and indicator register slice
`timescale 1ns/1ps
module an_indicator_properties #(
  parameter int unsigned stretch_cycles = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic tx_activity,
  input wire logic rx_activity,
  input wire logic link_up,
  input wire logic half_duplex,
  input wire logic speed_100,
  input wire logic collision,
  input wire logic port_indicator_a,
  input wire logic port_indicator_b,
  input wire logic port_indicator_c,
  input wire logic tx_pulse_tune,
  input wire logic link_alg_sel
);
  logic [7:0] idle;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) idle <= 8'h00;
    else if (tx_activity | rx_activity | link_up | half_duplex | speed_100 | collision)
      idle <= 8'h00;
    else if (idle != 8'hff) idle <= idle + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ta;
    $rose(mdio_oe) ##0 !mdio_out;
  endsequence
  property p_a_src;
    $rose(port_indicator_a) |-> $past(tx_activity | rx_activity | link_up | half_duplex);
  endproperty
  a_a_src: assert property (p_a_src) else $error("indicator a rose without source");
  property p_b_src;
    $rose(port_indicator_b) |-> $past(rx_activity | link_up | half_duplex | speed_100);
  endproperty
  a_b_src: assert property (p_b_src) else $error("indicator b rose without source");
  property p_c_src;
    $rose(port_indicator_c) |-> $past(link_up | half_duplex | speed_100 | collision);
  endproperty
  a_c_src: assert property (p_c_src) else $error("indicator c rose without source");
  property p_stretch;
    idle > stretch_cycles + 4 |-> !(port_indicator_a | port_indicator_b | port_indicator_c);
  endproperty
  a_stretch: assert property (p_stretch) else $error("indicator held too long");
  property p_tune;
    $changed(tx_pulse_tune) |-> mdc && !mdio_oe;
  endproperty
  a_tune: assert property (p_tune) else $error("tuning bit moved outside a write");
  property p_alg;
    $changed(link_alg_sel) |-> mdc && !mdio_oe;
  endproperty
  a_alg: assert property (p_alg) else $error("link algorithm moved outside a write");
  property p_ta_hold;
    s_ta |=> mdio_oe [*8];
  endproperty
  a_ta_hold: assert property (p_ta_hold) else $error("read drive too short");
  property p_oe_mdc;
    $rose(mdio_oe) |-> mdc;
  endproperty
  a_oe_mdc: assert property (p_oe_mdc) else $error("drive began off a clock rise");
endmodule // an_indicator_properties
bind an_expansion_and_indicator_regs an_indicator_properties #(
  .stretch_cycles(stretch_cycles)
) an_indicator_properties_inst (
  .clk              (clk),
  .rst_n            (rst_n),
  .mdc              (mdc),
  .mdio_out         (mdio_out),
  .mdio_oe          (mdio_oe),
  .tx_activity      (tx_activity),
  .rx_activity      (rx_activity),
  .link_up          (link_up),
  .half_duplex      (half_duplex),
  .speed_100        (speed_100),
  .collision        (collision),
  .port_indicator_a (port_indicator_a),
  .port_indicator_b (port_indicator_b),
  .port_indicator_c (port_indicator_c),
  .tx_pulse_tune    (tx_pulse_tune),
  .link_alg_sel     (link_alg_sel)
);

// File: testbench/mgmt_station.sv
// management station model for the serial management port
`timescale 1ns/1ps
module mgmt_station (
  // clock
  input  wire logic clk,
  // management pins
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      mdio_in
);
  logic drv = 1'b1;
  logic drv_en = 1'b0;
  initial mdc = 1'b0;
  // released line is pulled up
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [4:0] pa, input logic [1:0] op, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      if (i >= 48) rd = {rd[14:0], mdio_in};
      drv_en = !(op == 2'b10 && i >= 46);
      drv = f[63-i];
      half();
      mdc = 1'b1;
      half();
      mdc = 1'b0;
    end
    drv_en = 1'b0;
    // let the release settle before the next frame drives again
    half();
  endtask
endmodule // mgmt_station
